// [include/mda_pkg.sv]
// Constants for the on-board memory decode and auto-start block
package mda_pkg;
    localparam int          ADDR_W        = 16;
    localparam int          DATA_W        = 8;
    localparam logic [7:0]  CTRL_PORT     = 8'h7f;
    localparam int          SW_OUT_BIT    = 1;
    localparam int          HSK_BIT       = 0;
    localparam logic        SW_OUT_RST    = 1'b0;
    localparam logic        HSK_RST       = 1'b0;
    localparam logic        REDIR_RST     = 1'b1;
    localparam int          BOUND_LSB     = 12;
    localparam int          KB_LSB        = 10;
    localparam logic [3:0]  BOUND_ZERO    = 4'h0;
    localparam logic [2:0]  HI_DEFAULT    = 3'h7;
    localparam logic [1:0]  SZ_1K         = 2'h0;
    localparam logic [1:0]  SZ_2K         = 2'h1;
    localparam logic [1:0]  SZ_4K         = 2'h2;
    localparam logic [1:0]  SZ_8K         = 2'h3;
    localparam logic [2:0]  RAM_SLOT      = 3'h7;
    localparam logic [1:0]  SOCK3         = 2'h3;
    localparam logic [7:0]  RSVD_READ     = 8'h00;
endpackage : mda_pkg

// [hdl/mda_decode.sv]
// On-board memory decode, memory switch-out and auto-start redirection
`timescale 1ns/1ns
module mda_decode
    import mda_pkg::*;
#(
    parameter logic [2:0] START_HI = HI_DEFAULT
)(
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      clk_en,
    // Processor bus
    input  wire logic [mda_pkg::ADDR_W-1:0] cpu_addr,
    input  wire logic [mda_pkg::DATA_W-1:0] cpu_wdata,
    input  wire logic                      mem_rd,
    input  wire logic                      mem_wr,
    input  wire logic                      io_rd,
    input  wire logic                      io_wr,
    // Jumper straps
    input  wire logic                      start_lo_sel,
    input  wire logic                      start_hi_ovr,
    input  wire logic [2:0]                start_hi_val,
    input  wire logic [1:0]                chip_size,
    input  wire logic [2:0]                bank_sel,
    input  wire logic [7:0]                slot_fit,
    // Status into board_memory_switch_control read
    input  wire logic                      out_reply,
    input  wire logic                      in_avail_n,
    // Decode results
    output      logic [mda_pkg::ADDR_W-1:0] eff_addr,
    output      logic [3:0]                rom_sel,
    output      logic                      ram_sel,
    output      logic                      onboard_rd,
    output      logic                      ext_wr_en,
    output      logic                      ext_rd_en,
    // Board_memory_switch_control state
    output      logic [mda_pkg::DATA_W-1:0] port_rdata,
    output      logic                      mem_off,
    output      logic                      out_strobe,
    output      logic                      redirect
);

    ////////////////////////////////////////////////////////////////////////////
    logic          sw_off_ff;
    logic          hsk_ff;
    logic          redir_ff;
    logic          nxt_sw_off;
    logic          nxt_hsk;
    logic          nxt_redir;
    logic [3:0]    bound;
    logic [3:0]    hi_bits;
    logic          port_hit;
    logic          port_wr;
    logic          port_rd;
    logic [15:0]   map_addr;
    logic [2:0]    slot;
    logic          in_bank;
    logic [1:0]    sock;
    logic [7:0]    slot_hit;
    logic          any_hit;

    // Default boundary is E000/F000; override straps allow any 4K start
    assign hi_bits  = start_hi_ovr ? {start_hi_val, start_lo_sel} : {START_HI, start_lo_sel};
    assign bound    = hi_bits;
    assign port_hit = (cpu_addr[7:0] == CTRL_PORT);
    assign port_wr  = io_wr && port_hit;
    assign port_rd  = io_rd && port_hit;

    // Zero start never redirects, so the entry sequence is optional there
    assign nxt_redir  = port_rd ? 1'b0 : redir_ff;
    assign nxt_sw_off = port_wr ? cpu_wdata[SW_OUT_BIT] : sw_off_ff;
    assign nxt_hsk    = port_wr ? cpu_wdata[HSK_BIT] : hsk_ff;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sw_off_ff <= SW_OUT_RST;
            hsk_ff    <= HSK_RST;
            redir_ff  <= REDIR_RST;
        end
        else if (clk_en)
        begin
            sw_off_ff <= nxt_sw_off;
            hsk_ff    <= nxt_hsk;
            redir_ff  <= nxt_redir;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Only memory reads are forced; the fetch path is all that matters at entry
    assign redirect = redir_ff && (bound != BOUND_ZERO);
    assign map_addr = (redirect && mem_rd) ? {bound, cpu_addr[BOUND_LSB-1:0]} : cpu_addr;
    assign eff_addr = map_addr;

    // Bank/slot by chip size: slot index is three address bits above the chip size
    always_comb
    begin
        slot    = 3'h0;
        in_bank = 1'b0;
        case (chip_size)
            SZ_1K:
            begin
                slot    = map_addr[12:10];
                in_bank = (map_addr[15:13] == bank_sel);
            end
            SZ_2K:
            begin
                slot    = map_addr[13:11];
                in_bank = (map_addr[15:14] == bank_sel[1:0]);
            end
            SZ_4K:
            begin
                slot    = map_addr[14:12];
                in_bank = (map_addr[15] == bank_sel[0]);
            end
            SZ_8K:
            begin
                slot    = map_addr[15:13];
                in_bank = 1'b1;
            end
            default:
            begin
                slot    = 3'h0;
                in_bank = 1'b0;
            end
        endcase
    end

    // Slots 0-2 and 4-6 are sockets 0-2, slot 3 is socket 3, slot 7 the RAM
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_slot
            assign slot_hit[gi] = in_bank && (slot == 3'(gi)) && slot_fit[gi] && !sw_off_ff;
        end
    endgenerate

    assign sock    = slot[1:0];
    assign any_hit = |slot_hit;

    // RAM decodes only its 1K in larger slots, so it repeats across the slot
    assign ram_sel = slot_hit[RAM_SLOT] && (mem_rd || mem_wr);

    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_rom
            assign rom_sel[gi] = mem_rd && any_hit && (slot != RAM_SLOT) && (sock == 2'(gi));
        end
    endgenerate

    assign onboard_rd = mem_rd && any_hit;
    assign ext_rd_en  = mem_rd && !any_hit;
    // RAM writes go to the bus too; ROM writes stay off the bus
    assign ext_wr_en  = mem_wr && !(any_hit && (slot != RAM_SLOT));

    // Read of board_memory_switch_control: handshake status bits in the low lanes
    assign port_rdata = {RSVD_READ[7:2], in_avail_n, out_reply};
    assign mem_off    = sw_off_ff;
    assign out_strobe = hsk_ff;

    ////////////////////////////////////////////////////////////////////////////
    a_switch_write: assert property (@(posedge clk) disable iff (!rst_n)
        (rst_n && clk_en && port_wr) |=> (mem_off == $past(cpu_wdata[SW_OUT_BIT])))
        else $error("switch bit not taken from write");
    a_hsk_write: assert property (@(posedge clk) disable iff (!rst_n)
        (rst_n && clk_en && port_wr) |=> (out_strobe == $past(cpu_wdata[HSK_BIT])))
        else $error("handshake latch not taken from write");
    a_off_no_hit: assert property (@(posedge clk) disable iff (!rst_n)
        mem_off |-> (!ram_sel && rom_sel == 4'h0 && !onboard_rd))
        else $error("on-board memory answered while switched out");
    a_ram_wr_bus: assert property (@(posedge clk) disable iff (!rst_n)
        (ram_sel && mem_wr) |-> ext_wr_en)
        else $error("RAM write not passed to bus");
    a_reset_state: assert property (@(posedge clk)
        !rst_n |=> (!mem_off && (redirect == (bound != BOUND_ZERO))))
        else $error("reset state wrong");
    a_redir_addr: assert property (@(posedge clk) disable iff (!rst_n)
        (redirect && mem_rd) |-> (eff_addr == {bound, cpu_addr[11:0]}))
        else $error("redirected address wrong");
    a_redir_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (rst_n && clk_en && port_rd) |=> !redirect ##1 !redirect)
        else $error("port read did not clear redirection");
    a_zero_start: assert property (@(posedge clk) disable iff (!rst_n)
        (bound == BOUND_ZERO) |-> (!redirect && eff_addr == cpu_addr))
        else $error("zero start redirected");
    a_default_start: assert property (@(posedge clk) disable iff (!rst_n)
        !start_hi_ovr |-> (bound[3:1] == START_HI && bound[0] == start_lo_sel))
        else $error("default start not E000/F000");
    a_onboard_wins: assert property (@(posedge clk) disable iff (!rst_n)
        onboard_rd |-> !ext_rd_en)
        else $error("external read enabled over on-board memory");
    a_switch_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (rst_n && !port_wr) |=> $stable(mem_off))
        else $error("switch bit moved without a write");

endmodule : mda_decode

// [dv/mda_host.sv]
// Host processor bus model driving the decode block
`timescale 1ns/1ns
module mda_host (
    // Clock
    input  wire logic                       clk,
    // Processor bus
    output      logic [mda_pkg::ADDR_W-1:0] cpu_addr,
    output      logic [mda_pkg::DATA_W-1:0] cpu_wdata,
    output      logic                       mem_rd,
    output      logic                       mem_wr,
    output      logic                       io_rd,
    output      logic                       io_wr
);
    initial {cpu_addr, cpu_wdata, mem_rd, mem_wr, io_rd, io_wr} = '0;
    // Kind 1 mem read, 2 mem write, 3 io read, 4 io write, else idle
    task automatic cyc(input logic [2:0] k, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        cpu_addr <= a;
        cpu_wdata <= d;
        {mem_rd, mem_wr, io_rd, io_wr} <= {k == 3'h1, k == 3'h2, k == 3'h3, k == 3'h4};
    endtask : cyc
    // Entry code: fetch at zero, jump target, then port read
    task automatic boot(input int n);
        cyc(n == 2 ? 3'h3 : 3'h1, n == 2 ? 16'h007f : 16'(n * 3), 8'h00);
    endtask : boot
endmodule : mda_host

// [dv/test_mda_decode.sv]
// Self-checking bench for the memory decode and auto-start block
`timescale 1ns/1ns
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module test_mda_decode;
    import mda_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, lo_sel = 1'b0, hi_ovr = 1'b0;
    logic        clk_en = 1'b1, out_reply = 1'b1, in_avail_n = 1'b0;
    logic [2:0]  hi_val = 3'h0, bank = 3'h7;
    logic [1:0]  size = SZ_1K;
    logic [7:0]  fit = 8'hff;
    logic [15:0] cpu_addr, eff_addr;
    logic [7:0]  cpu_wdata, port_rdata;
    logic [3:0]  rom_sel;
    logic        mem_rd, mem_wr, io_rd, io_wr, ram_sel, onboard_rd, ext_wr_en, ext_rd_en;
    logic        mem_off, out_strobe, redirect;
    int          mismatches = 0, tests_run = 0, cycles = 0;
    // Address, bus kind, socket selects, {ram, ext write, ext read, on-board}
    logic [27:0] rows [9] = '{28'he000_1_1_1, 28'he400_1_2_1, 28'he800_1_4_1, 28'hec00_1_8_1,
        28'hf400_1_2_1, 28'hfc00_1_0_9, 28'hfc00_2_0_c, 28'he000_2_0_0, 28'h1000_1_0_2};
    mda_host host_inst (.clk, .cpu_addr, .cpu_wdata, .mem_rd, .mem_wr, .io_rd, .io_wr);
    mda_decode mda_decode_inst (.clk, .rst_n, .clk_en, .cpu_addr, .cpu_wdata, .mem_rd, .mem_wr,
        .io_rd, .io_wr, .start_lo_sel(lo_sel), .start_hi_ovr(hi_ovr), .start_hi_val(hi_val),
        .chip_size(size), .bank_sel(bank), .slot_fit(fit), .out_reply, .in_avail_n,
        .eff_addr, .rom_sel, .ram_sel, .onboard_rd, .ext_wr_en, .ext_rd_en, .port_rdata, .mem_off,
        .out_strobe, .redirect);
    initial forever #5 clk = ~clk;
    // Hang guard well above the expected run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            mismatches++;
            test_done();
        end
    end
    task automatic test_done();
        $display("counts: %0d compared, %0d mismatches", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task automatic reboot(input logic [3:0] b, input logic ovr);
        @(posedge clk);
        rst_n <= 1'b0;
        {hi_val, lo_sel, hi_ovr} <= {b, ovr};
        @(posedge clk);
        rst_n <= 1'b1;
    endtask : reboot
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        host_inst.boot(0);
        #1;
        `CHK("mem_off", 1'b0, mem_off)
        `CHK("strobe", 1'b0, out_strobe)
        `CHK("eff_addr", 16'he000, eff_addr)
        `CHK("rom_sel", 4'h1, rom_sel)
        host_inst.boot(1);
        #1;
        `CHK("eff_addr", 16'he003, eff_addr)
        host_inst.boot(2);
        #1;
        `CHK("port_rdata", 8'h01, port_rdata)
        host_inst.cyc(3'h1, 16'h0000, 8'h00);
        #1;
        `CHK("eff_addr", 16'h0000, eff_addr)
        $display("test autostart done");
        for (int i = 0; i < 9; i++)
        begin
            host_inst.cyc(rows[i][10:8], rows[i][27:12], 8'h00);
            #1;
            `CHK("rom_sel", rows[i][7:4], rom_sel)
            `CHK("flags", rows[i][3:0], {ram_sel, ext_wr_en, ext_rd_en, onboard_rd})
        end
        $display("test decode rows done");
        host_inst.cyc(3'h4, 16'h007f, 8'h03);
        host_inst.cyc(3'h1, 16'he000, 8'h00);
        #1;
        `CHK("mem_off", 1'b1, mem_off)
        `CHK("strobe", 1'b1, out_strobe)
        `CHK("rd_flags", 3'h2, {onboard_rd, ext_rd_en, rom_sel != 4'h0})
        host_inst.cyc(3'h4, 16'h007e, 8'h00);
        host_inst.cyc(3'h0, 16'h0000, 8'h00);
        #1;
        `CHK("mem_off", 1'b1, mem_off)
        host_inst.cyc(3'h4, 16'h007f, 8'h01);
        host_inst.cyc(3'h0, 16'h0000, 8'h00);
        #1;
        `CHK("mem_off", 1'b0, mem_off)
        `CHK("strobe", 1'b1, out_strobe)
        $display("test switch done");
        @(posedge clk);
        {size, bank} <= {SZ_2K, 3'h3};
        for (int a = 0; a < 2; a++)
        begin
            host_inst.cyc(3'h1, 16'hf800 + 16'(a * 1024), 8'h00);
            #1;
            `CHK("ram_sel", 1'b1, ram_sel)
        end
        @(posedge clk);
        fit <= 8'h7f;
        host_inst.cyc(3'h1, 16'hfc00, 8'h00);
        #1;
        `CHK("ram_ext", 2'h1, {ram_sel, ext_rd_en})
        $display("test sizes done");
        host_inst.cyc(3'h4, 16'h007f, 8'h02);
        // Idle the bus so the write is not taken again after release
        host_inst.cyc(3'h0, 16'h0000, 8'h00);
        #1;
        `CHK("mem_off", 1'b1, mem_off)
        for (int b = 0; b < 16; b++)
        begin
            reboot(4'(b), 1'b1);
            host_inst.cyc(3'h1, 16'h0123, 8'h00);
            #1;
            `CHK("mem_off", 1'b0, mem_off)
            `CHK("redirect", b != 0, redirect)
            `CHK("eff_addr", {4'(b), 12'h123}, eff_addr)
        end
        reboot(4'h1, 1'b0);
        host_inst.cyc(3'h1, 16'h0123, 8'h00);
        #1;
        `CHK("eff_addr", 16'hf123, eff_addr)
        // Frozen clock enable: port read and write must both be ignored
        host_inst.cyc(3'h3, 16'h007f, 8'h00);
        {clk_en, out_reply, in_avail_n} <= 3'b001;
        #1;
        `CHK("port_rdata", 8'h02, port_rdata)
        host_inst.cyc(3'h4, 16'h007f, 8'h03);
        host_inst.cyc(3'h0, 16'h0000, 8'h00);
        clk_en <= 1'b1;
        #1;
        `CHK("frozen", 3'h4, {redirect, mem_off, out_strobe})
        host_inst.cyc(3'h3, 16'h007f, 8'h00);
        host_inst.cyc(3'h0, 16'h0000, 8'h00);
        #1;
        `CHK("redirect", 1'b0, redirect)
        $display("test boundaries done");
        test_done();
    end
endmodule : test_mda_decode
